// >>> common/gcr_cfg.svh
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GCR_ADDR_ANA_HI 8'h00
`define GCR_ADDR_ANA_LO 8'h01
`define GCR_ADDR_PIN3   8'h02
`define GCR_ADDR_PIN2   8'h03
`define GCR_ADDR_PIN1   8'h04
`define GCR_ADDR_PIN0   8'h05
`define GCR_ADDR_MCU    8'h06
`define GCR_ADDR_TEST   8'hb4
`define GCR_ADDR_STAT   8'hf0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GCR_RST_ANA_HI  8'h0c
`define GCR_RST_ANA_LO  8'hc0
`define GCR_RST_PIN123  8'ha2
`define GCR_RST_PIN0    8'h0a
`define GCR_RST_MCU     8'h00
`define GCR_RST_TEST    8'h21

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GCR_F_GM        4:2
`define GCR_F_BLD       1:0
`define GCR_B_REFSEL    6
`define GCR_B_AES       5
`define GCR_B_EXTREF    4
`define GCR_B_BROWN     2
`define GCR_B_BATT      1
`define GCR_B_TEMP      0
`define GCR_F_PSEL      7:3
`define GCR_F_PMODE     1:0
`define GCR_B_MCU_EN    7
`define GCR_F_TAIL      6:5
`define GCR_F_XDIV      4:1
`define GCR_B_RDIV      0
`define GCR_B_PD        3
`define GCR_B_RD_CMD    0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define GCR_TAIL_1      10'h040
`define GCR_TAIL_2      10'h100
`define GCR_TAIL_3      10'h200
`define GCR_RC_LAST     7'h7f
`define GCR_ACC_STEP    10'h002

`endif

// >>> common/gcr_pkg.sv
package gcr_pkg;

	typedef enum logic [1:0] {
		gcr_st_cmd  = 2'b00,
		gcr_st_addr = 2'b01,
		gcr_st_data = 2'b10,
		gcr_st_idle = 2'b11
	} gcr_spi_state_e;

	typedef struct packed {
		logic           cs_m;
		logic           cs_s;
		logic           sck_m;
		logic           sck_s;
		logic           sck_p;
		logic           mosi_m;
		logic           mosi_s;
		gcr_spi_state_e st;
		logic [2:0]     cnt;
		logic [7:0]     sh;
		logic           rd_cmd;
		logic           pend;
		logic           rd;
		logic           wr;
		logic [7:0]     addr;
		logic [7:0]     wdata;
		logic [7:0]     obuf;
		logic           miso;
	} gcr_spi_s;

	typedef struct packed {
		logic [7:0]      ana_hi;
		logic [7:0]      ana_lo;
		logic [3:0][7:0] pin;
		logic [7:0]      mcu;
		logic [7:0]      test;
		logic            stat_warn;
		logic [3:0]      oe;
		logic            ana0;
		logic            rco_m;
		logic            rco_s;
		logic            rco_p;
		logic            src_rco;
		logic            stby_p;
		logic            stopped;
		logic [9:0]      acc;
		logic [9:0]      tail;
		logic [6:0]      rdiv;
		logic            tick;
	} gcr_bank_s;

endpackage

// >>> verilog/gcr_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"

module gcr_spi_slave (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       spi_sck,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	input  wire logic [7:0] rdata,
	output logic            spi_miso,
	output logic [7:0]      addr,
	output logic [7:0]      wdata,
	output logic            wr_pulse,
	output logic            rd_pulse
);

	gcr_pkg::gcr_spi_s r_q;
	gcr_pkg::gcr_spi_s r_d;
	logic              rise;
	logic              fall;

	assign rise = r_q.sck_s & ~r_q.sck_p;
	assign fall = ~r_q.sck_s & r_q.sck_p;

	always_comb begin
		r_d        = r_q;
		r_d.cs_m   = spi_cs_n;
		r_d.cs_s   = r_q.cs_m;
		r_d.sck_m  = spi_sck;
		r_d.sck_s  = r_q.sck_m;
		r_d.sck_p  = r_q.sck_s;
		r_d.mosi_m = spi_mosi;
		r_d.mosi_s = r_q.mosi_m;
		r_d.wr     = 1'b0;
		r_d.rd     = 1'b0;
		if (r_q.cs_s) begin
			r_d.st   = gcr_pkg::gcr_st_cmd;
			r_d.cnt  = 3'h0;
			r_d.obuf = 8'h00;
			r_d.miso = 1'b0;
			r_d.pend = 1'b0;
		end else begin
			if (rise) begin
				r_d.sh  = {r_q.sh[6:0], r_q.mosi_s};
				r_d.cnt = r_q.cnt + 3'h1;
				if (r_q.cnt == 3'h7) begin
					case (r_q.st)
						gcr_pkg::gcr_st_cmd: begin
							r_d.rd_cmd = r_d.sh[`GCR_B_RD_CMD];
							r_d.st     = gcr_pkg::gcr_st_addr;
						end
						gcr_pkg::gcr_st_addr: begin
							r_d.addr = r_d.sh;
							r_d.pend = r_q.rd_cmd;
							r_d.st   = gcr_pkg::gcr_st_data;
						end
						gcr_pkg::gcr_st_data: begin
							r_d.wdata = r_d.sh;
							r_d.wr    = ~r_q.rd_cmd;
							r_d.st    = gcr_pkg::gcr_st_idle;
						end
						default: r_d.st = gcr_pkg::gcr_st_idle;
					endcase
				end
			end
			if (fall) begin
				r_d.miso = r_q.obuf[7];
				r_d.obuf = {r_q.obuf[6:0], 1'b0};
			end
			// Capture one cycle after the address settles on the port
			if (r_q.pend) begin
				r_d.obuf = rdata;
				r_d.rd   = 1'b1;
				r_d.pend = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q      <= '0;
			r_q.cs_m <= 1'b1;
			r_q.cs_s <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign spi_miso = r_q.miso;
	assign addr     = r_q.addr;
	assign wdata    = r_q.wdata;
	assign wr_pulse = r_q.wr;
	assign rd_pulse = r_q.rd;

	a_wr_only_write: assert property (@(posedge clk) disable iff (!rst_n)
		r_q.wr |-> !r_q.rd_cmd && r_q.st == gcr_pkg::gcr_st_idle)
		else $error("write strobe from a read frame");

endmodule // gcr_spi_slave

`default_nettype wire

// >>> verilog/gcr_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"

// Functional notes
// - Read-and-clear register returns its content, then clears after the read.
// - Read/write registers store SPI writes and read back the full byte.
// - Battery-low threshold code 00..11 selects 2.7, 2.5, 2.3, 2.1 V.
// - Three-bit crystal driver strength, reset 011.
// - Reference select: 1 means 26 MHz, 0 means 24 MHz; reset 1.
// - Bit 5 of low analog register enables AES engine; reset off.
// - External reference select: 0 oscillator circuit, 1 crystal input pin.
// - Bits 2,1,0 enable brownout, battery detector, temperature sensor.
// - Pin selector in bits 7:3; pins 1 to 3 reset to ground code.
// - Pin 0 selector resets to power-on-reset signal code.
// - Pin mode 01 input, 10 low-power output, 11 high-power output.
// - Only pin 0 accepts mode 00 as analog mode.
// - Host clock enable bit runs the divider; pin must also select it.
// - Tail code gives 0, 64, 256 or 512 extra clocks before standby.
// - Bits 4:1 select the crystal clock division ratio; reset 0.
// - Bit 0 divides the RC clock by 1 or by 128.
// - Powerdown test bit stops both clock dividers; reset runs them.
// - Crystal codes map to ratios 1, 2/3, 1/2 down to 1/192.
// - Source moves to RC in sleep and back, only on RC clock edges.
// - Entering standby raises a warning no later than the host clock stops; with tail code 00 both come in the same cycle.
module gcr_bank (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_mosi,
	input  wire logic        rco_clk,
	input  wire logic        sleep_req,
	input  wire logic        standby_req,
	output logic             spi_miso,
	output logic [2:0]       xtal_driver_strength,
	output logic [1:0]       battery_low_threshold,
	output logic             ref_freq_select,
	output logic             aes_enable,
	output logic             external_reference_select,
	output logic             brownout_detect_enable,
	output logic             battery_low_detector_enable,
	output logic             temp_sensor_enable,
	output logic [3:0][4:0]  pin_select,
	output logic [3:0][1:0]  pin_mode,
	output logic [3:0]       pin_out_en,
	output logic             pin0_analog_en,
	output logic             clock_divider_powerdown,
	output logic             host_clk_tick,
	output logic             host_clk_on_rc,
	output logic             host_clk_stopped,
	output logic             standby_warn
);

	// ----------------------------------------
	// Register access port
	// ----------------------------------------
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr_pulse;
	logic       rd_pulse;
	logic [7:0] rdata;

	gcr_spi_slave u_spi (
		.clk      (clk),
		.rst_n    (rst_n),
		.spi_sck  (spi_sck),
		.spi_cs_n (spi_cs_n),
		.spi_mosi (spi_mosi),
		.rdata    (rdata),
		.spi_miso (spi_miso),
		.addr     (addr),
		.wdata    (wdata),
		.wr_pulse (wr_pulse),
		.rd_pulse (rd_pulse)
	);

	gcr_pkg::gcr_bank_s r_q;
	gcr_pkg::gcr_bank_s r_d;
	logic               rco_rise;
	logic               stby_rise;
	logic               run;
	logic [9:0]         per;
	logic [9:0]         sum;
	logic [9:0]         tail_len;

	assign rco_rise  = r_q.rco_s & ~r_q.rco_p;
	assign stby_rise = standby_req & ~r_q.stby_p;
	assign run       = r_q.mcu[`GCR_B_MCU_EN] & ~r_q.test[`GCR_B_PD] & ~r_q.stopped;
	assign sum       = r_q.acc + `GCR_ACC_STEP;

	// ----------------------------------------
	// Crystal divider period in half cycles
	// ----------------------------------------
	// Half-cycle units let the 2/3 ratio run as alternating 1 and 2 cycles
	function automatic logic [9:0] xo_period(input logic [3:0] code);
		case (code)
			4'h0:    xo_period = 10'h002;
			4'h1:    xo_period = 10'h003;
			4'h2:    xo_period = 10'h004;
			4'h3:    xo_period = 10'h006;
			4'h4:    xo_period = 10'h008;
			4'h5:    xo_period = 10'h00c;
			4'h6:    xo_period = 10'h010;
			4'h7:    xo_period = 10'h018;
			4'h8:    xo_period = 10'h020;
			4'h9:    xo_period = 10'h030;
			4'ha:    xo_period = 10'h048;
			4'hb:    xo_period = 10'h060;
			4'hc:    xo_period = 10'h080;
			4'hd:    xo_period = 10'h0c0;
			4'he:    xo_period = 10'h100;
			default: xo_period = 10'h180;
		endcase
	endfunction

	assign per = xo_period(r_q.mcu[`GCR_F_XDIV]);

	always_comb begin
		case (r_q.mcu[`GCR_F_TAIL])
			2'b00:   tail_len = 10'h000;
			2'b01:   tail_len = `GCR_TAIL_1;
			2'b10:   tail_len = `GCR_TAIL_2;
			default: tail_len = `GCR_TAIL_3;
		endcase
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		case (addr)
			`GCR_ADDR_ANA_HI: rdata = r_q.ana_hi;
			`GCR_ADDR_ANA_LO: rdata = r_q.ana_lo;
			`GCR_ADDR_PIN3:   rdata = r_q.pin[3];
			`GCR_ADDR_PIN2:   rdata = r_q.pin[2];
			`GCR_ADDR_PIN1:   rdata = r_q.pin[1];
			`GCR_ADDR_PIN0:   rdata = r_q.pin[0];
			`GCR_ADDR_MCU:    rdata = r_q.mcu;
			`GCR_ADDR_TEST:   rdata = r_q.test;
			`GCR_ADDR_STAT:   rdata = {7'h00, r_q.stat_warn};
			default:          rdata = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_d        = r_q;
		r_d.rco_m  = rco_clk;
		r_d.rco_s  = r_q.rco_m;
		r_d.rco_p  = r_q.rco_s;
		r_d.stby_p = standby_req;
		r_d.tick   = 1'b0;

		// Whole bytes stored, so reserved bits keep what the host writes back
		if (wr_pulse) begin
			case (addr)
				`GCR_ADDR_ANA_HI: r_d.ana_hi = wdata;
				`GCR_ADDR_ANA_LO: r_d.ana_lo = wdata;
				`GCR_ADDR_PIN3:   r_d.pin[3] = wdata;
				`GCR_ADDR_PIN2:   r_d.pin[2] = wdata;
				`GCR_ADDR_PIN1:   r_d.pin[1] = wdata;
				`GCR_ADDR_PIN0:   r_d.pin[0] = wdata;
				`GCR_ADDR_MCU:    r_d.mcu    = wdata;
				`GCR_ADDR_TEST:   r_d.test   = wdata;
				default:          r_d.ana_hi = r_q.ana_hi;
			endcase
		end

		// Clear after read; a new standby entry in the same cycle wins
		if (rd_pulse && addr == `GCR_ADDR_STAT) begin
			r_d.stat_warn = 1'b0;
		end
		if (stby_rise) begin
			r_d.stat_warn = 1'b1;
		end

		// Mode bit 1 set means an output mode
		for (int i = 0; i < 4; i++) begin
			r_d.oe[i] = r_d.pin[i][1];
		end
		r_d.ana0 = (r_d.pin[0][`GCR_F_PMODE] == 2'b00);

		// Source switch only at an RC edge avoids a runt pulse to the host
		if (rco_rise) begin
			r_d.src_rco = sleep_req;
		end

		if (!run) begin
			r_d.acc  = 10'h000;
			r_d.rdiv = 7'h00;
		end else if (r_q.src_rco) begin
			r_d.acc = 10'h000;
			if (rco_rise) begin
				r_d.rdiv = r_q.rdiv + 7'h01;
				r_d.tick = ~r_q.mcu[`GCR_B_RDIV] | (r_q.rdiv == `GCR_RC_LAST);
			end
		end else begin
			r_d.rdiv = 7'h00;
			if (sum >= per) begin
				r_d.tick = 1'b1;
				r_d.acc  = sum - per;
			end else begin
				r_d.acc = sum;
			end
		end

		// Standby tail counted in delivered host clock periods
		if (!standby_req) begin
			r_d.stopped = 1'b0;
			r_d.tail    = 10'h000;
		end else if (stby_rise) begin
			r_d.tail    = tail_len;
			r_d.stopped = (tail_len == 10'h000);
		end else if (r_d.tick && r_q.tail != 10'h000) begin
			r_d.tail = r_q.tail - 10'h001;
			if (r_q.tail == 10'h001) begin
				r_d.stopped = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q        <= '0;
			r_q.ana_hi <= `GCR_RST_ANA_HI;
			r_q.ana_lo <= `GCR_RST_ANA_LO;
			r_q.pin[3] <= `GCR_RST_PIN123;
			r_q.pin[2] <= `GCR_RST_PIN123;
			r_q.pin[1] <= `GCR_RST_PIN123;
			r_q.pin[0] <= `GCR_RST_PIN0;
			r_q.mcu    <= `GCR_RST_MCU;
			r_q.test   <= `GCR_RST_TEST;
			r_q.oe     <= 4'hf;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign xtal_driver_strength        = r_q.ana_hi[`GCR_F_GM];
	assign battery_low_threshold       = r_q.ana_hi[`GCR_F_BLD];
	assign ref_freq_select             = r_q.ana_lo[`GCR_B_REFSEL];
	assign aes_enable                  = r_q.ana_lo[`GCR_B_AES];
	assign external_reference_select   = r_q.ana_lo[`GCR_B_EXTREF];
	assign brownout_detect_enable      = r_q.ana_lo[`GCR_B_BROWN];
	assign battery_low_detector_enable = r_q.ana_lo[`GCR_B_BATT];
	assign temp_sensor_enable          = r_q.ana_lo[`GCR_B_TEMP];
	assign clock_divider_powerdown     = r_q.test[`GCR_B_PD];
	assign pin0_analog_en              = r_q.ana0;
	assign pin_out_en                  = r_q.oe;
	assign host_clk_tick               = r_q.tick;
	assign host_clk_on_rc              = r_q.src_rco;
	assign host_clk_stopped            = r_q.stopped;
	assign standby_warn                = r_q.stat_warn;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_select[i] = r_q.pin[i][`GCR_F_PSEL];
			pin_mode[i]   = r_q.pin[i][`GCR_F_PMODE];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_stby_enter;
		standby_req && !r_q.stby_p;
	endsequence

	sequence s_stat_read;
		rd_pulse && addr == `GCR_ADDR_STAT;
	endsequence

	a_rr_read_clears: assert property (s_stat_read ##0 !stby_rise |=> !r_q.stat_warn)
		else $error("status not cleared by read");
	a_rw_write_back: assert property (wr_pulse && addr == `GCR_ADDR_MCU |=> r_q.mcu == $past(wdata))
		else $error("control register lost write");
	a_ana_lo_fields: assert property (wr_pulse && addr == `GCR_ADDR_ANA_LO |=>
		{ref_freq_select, aes_enable, external_reference_select} == $past(wdata[6:4]))
		else $error("analog enables not taken from write");
	a_thr_gm_fields: assert property (wr_pulse && addr == `GCR_ADDR_ANA_HI |=>
		{xtal_driver_strength, battery_low_threshold} == $past(wdata[4:0]))
		else $error("threshold or driver field wrong");
	a_analog_only_p0: assert property (wr_pulse && addr == `GCR_ADDR_PIN0 |=>
		pin0_analog_en == ($past(wdata[1:0]) == 2'b00))
		else $error("pin 0 analog flag wrong");
	a_src_on_rc_edge: assert property (r_q.src_rco != r_d.src_rco |-> rco_rise)
		else $error("source switched off an RC edge");
	a_warn_on_stby: assert property (s_stby_enter |=> standby_warn ##0 host_clk_stopped == (tail_len == 10'h000))
		else $error("standby entry not flagged");
	a_powerdown_idle: assert property (clock_divider_powerdown |=> !host_clk_tick)
		else $error("clock tick while dividers are off");
	a_enable_gates: assert property (!r_q.mcu[`GCR_B_MCU_EN] |=> !host_clk_tick)
		else $error("clock tick while host clock disabled");
	a_rc_div_one: assert property (run && r_q.src_rco && !r_q.mcu[`GCR_B_RDIV] && rco_rise |=> host_clk_tick)
		else $error("RC clock not passed at ratio one");
	a_xo_div_one: assert property ((run && !r_q.src_rco && r_q.mcu[`GCR_F_XDIV] == 4'h0) [*2] |=> host_clk_tick)
		else $error("crystal ratio one misses a cycle");

endmodule // gcr_bank

`default_nettype wire

// >>> bench/gcr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host side of the register port
// ----------------------------------------
module gcr_spi_host (
	input  wire logic clk,
	input  wire logic spi_miso,
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_mosi
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Mode 0, MSB first; half period of 8 clocks keeps above the 6 clock floor
	task automatic frame(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [23:0] sh;
		sh = {7'h00, rd, a, d};
		q = 8'h00;
		tk(1);
		spi_cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_mosi = sh[i];
			tk(8);
			spi_sck = 1'b1;
			if (i < 8)
				q = {q[6:0], spi_miso};
			tk(8);
			spi_sck = 1'b0;
		end
		tk(8);
		spi_cs_n = 1'b1;
		// Released line must not keep a stale bit
		spi_mosi = ~spi_mosi;
		tk(6);
	endtask
endmodule // gcr_spi_host

`default_nettype wire

// >>> bench/gcr_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", n, e, s); end end

module gcr_bank_tb;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] q;
	} gcr_tb_row_s;

	logic            clk;
	logic            rst_n;
	logic            spi_sck;
	logic            spi_cs_n;
	logic            spi_mosi;
	logic            rco_clk;
	logic            sleep_req;
	logic            standby_req;
	logic            spi_miso;
	logic [2:0]      xtal_driver_strength;
	logic [1:0]      battery_low_threshold;
	logic            ref_freq_select;
	logic            aes_enable;
	logic            external_reference_select;
	logic            brownout_detect_enable;
	logic            battery_low_detector_enable;
	logic            temp_sensor_enable;
	logic [3:0][4:0] pin_select;
	logic [3:0][1:0] pin_mode;
	logic [3:0]      pin_out_en;
	logic            pin0_analog_en;
	logic            clock_divider_powerdown;
	logic            host_clk_tick;
	logic            host_clk_on_rc;
	logic            host_clk_stopped;
	logic            standby_warn;
	int              mismatches = 0;
	int              cmp_count = 0;
	int              n;
	int              e;
	logic [7:0]      q;
	logic [7:0]      sh [9];
	logic [7:0]      adr [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hb4};
	logic [7:0]      rst [8] = '{8'h0c, 8'hc0, 8'ha2, 8'ha2, 8'ha2, 8'h0a, 8'h00, 8'h21};
	int              per [16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 72, 96, 128, 192, 256, 384};
	int              tails [4] = '{0, 64, 256, 512};
	gcr_tb_row_s     rows [15] = '{
		'{8'h00, 8'h0d, 8'h0d},
		'{8'h00, 8'h0e, 8'h0e},
		'{8'h00, 8'h1f, 8'h1f},
		'{8'h00, 8'he0, 8'he0},
		'{8'h01, 8'h3f, 8'h3f},
		'{8'h01, 8'hc0, 8'hc0},
		'{8'h05, 8'h00, 8'h00},
		'{8'h05, 8'hf9, 8'hf9},
		'{8'h02, 8'h0b, 8'h0b},
		'{8'h03, 8'ha4, 8'ha4},
		'{8'h04, 8'h88, 8'h88},
		'{8'h06, 8'h5a, 8'h5a},
		'{8'hb4, 8'h29, 8'h29},
		'{8'hb4, 8'h21, 8'h21},
		'{8'h07, 8'h55, 8'h00}
	};

	gcr_spi_host gcr_spi_host_i (
		.clk      (clk),
		.spi_miso (spi_miso),
		.spi_sck  (spi_sck),
		.spi_cs_n (spi_cs_n),
		.spi_mosi (spi_mosi)
	);

	gcr_bank gcr_bank_i (
		.clk                         (clk),
		.rst_n                       (rst_n),
		.spi_sck                     (spi_sck),
		.spi_cs_n                    (spi_cs_n),
		.spi_mosi                    (spi_mosi),
		.rco_clk                     (rco_clk),
		.sleep_req                   (sleep_req),
		.standby_req                 (standby_req),
		.spi_miso                    (spi_miso),
		.xtal_driver_strength        (xtal_driver_strength),
		.battery_low_threshold       (battery_low_threshold),
		.ref_freq_select             (ref_freq_select),
		.aes_enable                  (aes_enable),
		.external_reference_select   (external_reference_select),
		.brownout_detect_enable      (brownout_detect_enable),
		.battery_low_detector_enable (battery_low_detector_enable),
		.temp_sensor_enable          (temp_sensor_enable),
		.pin_select                  (pin_select),
		.pin_mode                    (pin_mode),
		.pin_out_en                  (pin_out_en),
		.pin0_analog_en              (pin0_analog_en),
		.clock_divider_powerdown     (clock_divider_powerdown),
		.host_clk_tick               (host_clk_tick),
		.host_clk_on_rc              (host_clk_on_rc),
		.host_clk_stopped            (host_clk_stopped),
		.standby_warn                (standby_warn)
	);

	always #5 clk = ~clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tk(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] x;
		gcr_spi_host_i.frame(1'b0, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] x);
		gcr_spi_host_i.frame(1'b1, a, 8'h00, x);
	endtask

	task automatic count(input int c, output int k);
		k = 0;
		repeat (c) begin
			tk(1);
			if (host_clk_tick === 1'b1)
				k++;
		end
	endtask

	function automatic int idx(input logic [7:0] a);
		return (a == 8'hb4) ? 7 : ((a < 8'h07) ? int'(a) : 8);
	endfunction

	task automatic chk_out;
		`CHK("gm", sh[0][4:2], xtal_driver_strength)
		`CHK("bld", sh[0][1:0], battery_low_threshold)
		`CHK("ref", sh[1][6:4], {ref_freq_select, aes_enable, external_reference_select})
		`CHK("mon", sh[1][2:0], {brownout_detect_enable, battery_low_detector_enable, temp_sensor_enable})
		for (int p = 0; p < 4; p++) begin
			`CHK("sel", sh[5 - p][7:3], pin_select[p])
			`CHK("mode", sh[5 - p][1:0], pin_mode[p])
			`CHK("oe", sh[5 - p][1], pin_out_en[p])
		end
		`CHK("ana", (sh[5][1:0] == 2'b00), pin0_analog_en)
		`CHK("pd", sh[7][3], clock_divider_powerdown)
	endtask

	task automatic wrap_up;
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Free running RC clock, period 14 clocks
	initial begin
		rco_clk = 1'b0;
		forever begin
			repeat (7) @(posedge clk);
			#1 rco_clk = ~rco_clk;
		end
	end

	// Whole run is about 52k cycles
	initial begin
		#900000;
		mismatches++;
		wrap_up();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		sleep_req = 1'b0;
		standby_req = 1'b0;
		tk(8);
		rst_n = 1'b1;
		tk(4);
		for (int i = 0; i < 8; i++) begin
			sh[i] = rst[i];
			rd(adr[i], q);
			`CHK("reset", rst[i], q)
		end
		chk_out();
		foreach (rows[r]) begin
			sh[idx(rows[r].a)] = rows[r].d;
			wr(rows[r].a, rows[r].d);
			rd(rows[r].a, q);
			`CHK("readback", rows[r].q, q)
			chk_out();
		end
		count(100, n);
		`CHK("ticks_off", 0, n)
		wr(8'hb4, 8'h29);
		wr(8'h06, 8'h80);
		count(100, n);
		`CHK("ticks_pd", 0, n)
		wr(8'hb4, 8'h21);
		for (int x = 0; x < 16; x++) begin
			wr(8'h06, {1'b1, 2'b00, x[3:0], 1'b0});
			count(1152, n);
			e = 2304 / per[x];
			`CHK("ratio", 1'b1, (n + 1 >= e && n <= e + 1))
		end
		for (int t = 0; t < 4; t++) begin
			wr(8'h06, {1'b1, t[1:0], 5'h00});
			standby_req = 1'b1;
			n = 0;
			for (int c = 0; c < 600 && host_clk_stopped !== 1'b1; c++) begin
				tk(1);
				if (host_clk_tick === 1'b1 && host_clk_stopped !== 1'b1)
					n++;
			end
			`CHK("tail", 1'b1, (n >= tails[t] && n <= tails[t] + 1))
			`CHK("stopped", 1'b1, host_clk_stopped)
			`CHK("warn", 1'b1, standby_warn)
			rd(8'hf0, q);
			`CHK("stat", 8'h01, q)
			`CHK("warn_clr", 1'b0, standby_warn)
			rd(8'hf0, q);
			`CHK("stat_clr", 8'h00, q)
			standby_req = 1'b0;
			tk(3);
			`CHK("restart", 1'b0, host_clk_stopped)
		end
		wr(8'h06, 8'h80);
		sleep_req = 1'b1;
		for (int c = 0; c < 60 && host_clk_on_rc !== 1'b1; c++)
			tk(1);
		`CHK("on_rc", 1'b1, host_clk_on_rc)
		count(280, n);
		`CHK("rc_div1", 1'b1, (n >= 19 && n <= 21))
		wr(8'h06, 8'h81);
		count(3584, n);
		`CHK("rc_div128", 1'b1, (n >= 1 && n <= 3))
		sleep_req = 1'b0;
		for (int c = 0; c < 60 && host_clk_on_rc !== 1'b0; c++)
			tk(1);
		`CHK("on_xo", 1'b0, host_clk_on_rc)
		rst_n = 1'b0;
		tk(2);
		rst_n = 1'b1;
		tk(4);
		rd(8'h00, q);
		`CHK("rereset", 8'h0c, q)
		`CHK("rereset_oe", 4'hf, pin_out_en)
		wrap_up();
	end
endmodule // gcr_bank_tb

`undef CHK
`default_nettype wire
